/* File: logic/ptd_pkg.sv */
// package: constants, types and register map of the descriptor walker
package ptd_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ROOT = 8'h04;
	localparam logic [7:0] OFS_VADDR = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_PHYS = 8'h10;
	localparam logic [7:0] OFS_ATTR = 8'h14;
	localparam logic [7:0] OFS_DESC1 = 8'h18;
	localparam logic [7:0] OFS_DESC2 = 8'h1c;
	localparam int ADDR_W = 8;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_START_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_SECT_FAULT_BIT = 2;
	localparam int ST_PAGE_FAULT_BIT = 3;
	localparam int ST_SIZE_LSB = 4;
	localparam int ROOT_LSB = 14;
	localparam int ATTR_CB_LSB = 4;
	localparam int ATTR_PERM_LSB = 8;
	localparam int ATTR_SINGLE_BIT = 16;
	localparam logic [1:0] DESC_INVALID = 2'b00;
	localparam logic [1:0] DESC_L1_COARSE = 2'b01;
	localparam logic [1:0] DESC_L1_SECTION = 2'b10;
	localparam logic [1:0] DESC_L1_FINE = 2'b11;
	localparam logic [1:0] DESC_L2_LARGE = 2'b01;
	localparam logic [1:0] DESC_L2_SMALL = 2'b10;
	localparam logic [1:0] DESC_L2_TINY = 2'b11;
	// ****************************************
	// reset values and bus answers
	// ****************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {SZ_SECTION, SZ_LARGE, SZ_SMALL, SZ_TINY} ptd_size_t;
	typedef enum {ST_IDLE, ST_FETCH1, ST_FETCH2} ptd_state_t;
	typedef enum {K_SECT_FAULT, K_COARSE, K_SECTION, K_FINE, K_PAGE_FAULT, K_PAGE} ptd_kind_t;
endpackage : ptd_pkg

/* File: logic/ptd_dec_if.sv */
// interface: descriptor and its decoded fields between walker and decoder
`timescale 1ns/1ps
`default_nettype none
interface ptd_dec_if;
	import ptd_pkg::*;
	logic [31:0] desc;
	logic [31:0] modified_virtual_addr;
	logic second_level;
	logic fine_table;
	ptd_kind_t kind;
	ptd_size_t size;
	logic [31:0] next_addr;
	logic [31:0] phys_addr;
	logic [3:0] domain;
	logic [7:0] perms;
	logic perm_single;
	logic [1:0] cb;
	modport walker (output desc, modified_virtual_addr, second_level, fine_table,
		input kind, size, next_addr, phys_addr, domain, perms, perm_single, cb);
	modport decoder (input desc, modified_virtual_addr, second_level, fine_table,
		output kind, size, next_addr, phys_addr, domain, perms, perm_single, cb);
endinterface : ptd_dec_if
`default_nettype wire

/* File: logic/ptd_desc_decode.sv */
// module: combinational decode of first- and second-level descriptors
`timescale 1ns/1ps
`default_nettype none
module ptd_desc_decode (
	ptd_dec_if.decoder dec
);
	import ptd_pkg::*;
	always_comb
	begin
		dec.kind = K_SECT_FAULT;
		dec.size = SZ_SECTION;
		dec.next_addr = RST_WORD;
		dec.phys_addr = RST_WORD;
		dec.domain = dec.desc[8:5];
		dec.perms = {6'h00, dec.desc[11:10]};
		dec.perm_single = 1'b1;
		dec.cb = dec.desc[3:2];
		if (!dec.second_level)
		begin
			unique case (dec.desc[1:0])
				DESC_INVALID: dec.kind = K_SECT_FAULT;
				DESC_L1_SECTION:
				begin
					dec.kind = K_SECTION;
					dec.phys_addr = {dec.desc[31:20], dec.modified_virtual_addr[19:0]};
				end
				DESC_L1_COARSE:
				begin
					dec.kind = K_COARSE;
					dec.next_addr = {dec.desc[31:10], dec.modified_virtual_addr[19:12], 2'b00};
				end
				DESC_L1_FINE:
				begin
					dec.kind = K_FINE;
					dec.next_addr = {dec.desc[31:12], dec.modified_virtual_addr[19:10], 2'b00};
				end
			endcase
		end
		else
		begin
			dec.kind = K_PAGE;
			dec.perms = dec.desc[11:4];
			dec.perm_single = 1'b0;
			unique case (dec.desc[1:0])
				DESC_INVALID: dec.kind = K_PAGE_FAULT;
				DESC_L2_LARGE:
				begin
					dec.size = SZ_LARGE;
					dec.phys_addr = {dec.desc[31:16], dec.modified_virtual_addr[15:0]};
				end
				DESC_L2_SMALL:
				begin
					dec.size = SZ_SMALL;
					dec.phys_addr = {dec.desc[31:12], dec.modified_virtual_addr[11:0]};
				end
				DESC_L2_TINY:
				begin
					dec.size = SZ_TINY;
					dec.phys_addr = {dec.desc[31:10], dec.modified_virtual_addr[9:0]};
					dec.perms = {6'h00, dec.desc[5:4]};
					dec.perm_single = 1'b1;
				end
			endcase
		end
	end
endmodule : ptd_desc_decode
`default_nettype wire

/* File: logic/ptd_walker.sv */
// module: table walker with descriptor decode and an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ptd_walker (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic [ptd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ptd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic MEM_RD_REQ,
	output logic [31:0] MEM_RD_ADDR,
	input wire logic MEM_RD_ACK,
	input wire logic [31:0] MEM_RD_DATA,
	output logic WALK_DONE
);
	import ptd_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		return (addr[1:0] == 2'b00) && (addr <= OFS_DESC2);
	endfunction : is_mapped

	// ****************************************
	// state
	// ****************************************
	ptd_state_t state_r;
	ptd_size_t size_r;
	logic [31:0] root_r, vaddr_r, phys_r, desc1_r, desc2_r, w_data_r, rd_word;
	logic busy_r, done_r, sect_fault_r, page_fault_r, single_r, fine_r, aw_got_r, w_got_r;
	logic [3:0] domain_r, w_strb_r;
	logic [1:0] cb_r;
	logic [7:0] perms_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic wr_fire, start_req, done_clr, mem_take, finish;
	ptd_dec_if dec ();
	ptd_desc_decode u_decode (.dec(dec));

	assign dec.desc = MEM_RD_DATA;
	assign dec.modified_virtual_addr = vaddr_r;
	assign dec.second_level = (state_r == ST_FETCH2);
	assign dec.fine_table = fine_r;

	// ****************************************
	// register bus: write channels
	// ****************************************
	assign wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID;
	assign start_req = wr_fire && (aw_addr_r == OFS_CTRL) && w_strb_r[0]
		&& w_data_r[CTRL_START_BIT];
	assign done_clr = wr_fire && (aw_addr_r == OFS_STATUS) && w_strb_r[0]
		&& w_data_r[ST_DONE_BIT];

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= RST_WORD;
			w_strb_r <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_addr_r <= S_AXI_AWADDR;
				aw_got_r <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
				w_got_r <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// ****************************************
	// software-written registers
	// ****************************************
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			root_r <= RST_WORD;
			vaddr_r <= RST_WORD;
		end
		else if (wr_fire)
		begin
			if (aw_addr_r == OFS_ROOT)
			begin
				root_r <= apply_strb(root_r, w_data_r, w_strb_r);
			end
			if (aw_addr_r == OFS_VADDR && !busy_r)
			begin
				vaddr_r <= apply_strb(vaddr_r, w_data_r, w_strb_r);
			end
		end
	end

	// ****************************************
	// register bus: read channel
	// ****************************************
	always_comb
	begin
		rd_word = RST_WORD;
		unique case (S_AXI_ARADDR)
			OFS_ROOT: rd_word = {root_r[31:ROOT_LSB], {ROOT_LSB{1'b0}}};
			OFS_VADDR: rd_word = vaddr_r;
			OFS_STATUS:
			begin
				rd_word[ST_BUSY_BIT] = busy_r;
				rd_word[ST_DONE_BIT] = done_r;
				rd_word[ST_SECT_FAULT_BIT] = sect_fault_r;
				rd_word[ST_PAGE_FAULT_BIT] = page_fault_r;
				rd_word[ST_SIZE_LSB +: 2] = size_r;
			end
			OFS_PHYS: rd_word = phys_r;
			OFS_ATTR:
			begin
				rd_word[3:0] = domain_r;
				rd_word[ATTR_CB_LSB +: 2] = cb_r;
				rd_word[ATTR_PERM_LSB +: 8] = perms_r;
				rd_word[ATTR_SINGLE_BIT] = single_r;
			end
			OFS_DESC1: rd_word = desc1_r;
			OFS_DESC2: rd_word = desc2_r;
			default: rd_word = RST_WORD;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= RST_WORD;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_word;
			S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// ****************************************
	// walk sequencer
	// ****************************************
	assign mem_take = MEM_RD_REQ && MEM_RD_ACK;
	assign finish = mem_take && ((state_r == ST_FETCH2)
		|| (dec.kind == K_SECTION) || (dec.kind == K_SECT_FAULT));

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			state_r <= ST_IDLE;
			busy_r <= 1'b0;
			MEM_RD_REQ <= 1'b0;
			MEM_RD_ADDR <= RST_WORD;
			fine_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (start_req)
					begin
						state_r <= ST_FETCH1;
						busy_r <= 1'b1;
						MEM_RD_REQ <= 1'b1;
						MEM_RD_ADDR <= {root_r[31:ROOT_LSB], vaddr_r[31:20], 2'b00};
					end
				end
				ST_FETCH1:
				begin
					if (mem_take)
					begin
						if (dec.kind == K_COARSE || dec.kind == K_FINE)
						begin
							state_r <= ST_FETCH2;
							MEM_RD_ADDR <= dec.next_addr;
							fine_r <= (dec.kind == K_FINE);
						end
						else
						begin
							state_r <= ST_IDLE;
							busy_r <= 1'b0;
							MEM_RD_REQ <= 1'b0;
						end
					end
				end
				ST_FETCH2:
				begin
					if (mem_take)
					begin
						state_r <= ST_IDLE;
						busy_r <= 1'b0;
						MEM_RD_REQ <= 1'b0;
					end
				end
			endcase
		end
	end

	// ****************************************
	// walk results
	// ****************************************
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			sect_fault_r <= 1'b0;
			page_fault_r <= 1'b0;
			size_r <= SZ_SECTION;
			phys_r <= RST_WORD;
			domain_r <= 4'h0;
			cb_r <= 2'b00;
			perms_r <= 8'h00;
			single_r <= 1'b0;
			desc1_r <= RST_WORD;
			desc2_r <= RST_WORD;
		end
		else if (start_req && state_r == ST_IDLE)
		begin
			sect_fault_r <= 1'b0;
			page_fault_r <= 1'b0;
		end
		else if (mem_take && state_r == ST_FETCH1)
		begin
			desc1_r <= MEM_RD_DATA;
			desc2_r <= RST_WORD;
			sect_fault_r <= (dec.kind == K_SECT_FAULT);
			if (dec.kind != K_SECT_FAULT)
			begin
				domain_r <= dec.domain;
			end
			if (dec.kind == K_SECTION)
			begin
				size_r <= SZ_SECTION;
				phys_r <= dec.phys_addr;
				perms_r <= dec.perms;
				single_r <= dec.perm_single;
				cb_r <= dec.cb;
			end
		end
		else if (mem_take && state_r == ST_FETCH2)
		begin
			desc2_r <= MEM_RD_DATA;
			page_fault_r <= (dec.kind == K_PAGE_FAULT);
			if (dec.kind == K_PAGE)
			begin
				size_r <= dec.size;
				phys_r <= dec.phys_addr;
				perms_r <= dec.perms;
				single_r <= dec.perm_single;
				cb_r <= dec.cb;
			end
		end
	end

	// sticky done: a completion in the clearing cycle wins
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			done_r <= 1'b0;
			WALK_DONE <= 1'b0;
		end
		else
		begin
			WALK_DONE <= finish;
			if (finish)
			begin
				done_r <= 1'b1;
			end
			else if (done_clr || start_req)
			begin
				done_r <= 1'b0;
			end
		end
	end
endmodule : ptd_walker
`default_nettype wire

/* File: bench/ptd_walker_checker.sv */
// checker: timing relations on the walker memory and bus ports
`timescale 1ns/1ps
`default_nettype none
module ptd_walker_checker (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic MEM_RD_REQ,
	input wire logic [31:0] MEM_RD_ADDR,
	input wire logic MEM_RD_ACK,
	input wire logic [31:0] MEM_RD_DATA,
	input wire logic WALK_DONE
);
	// ****************************************
	// fetch level tracking and assertions
	// ****************************************
	logic tk;
	logic lvl2_r;
	logic [31:0] d_last_r;
	assign tk = MEM_RD_REQ && MEM_RD_ACK;
	always_ff @(posedge SYS_CLK)
	begin
		if (tk)
			d_last_r <= MEM_RD_DATA;
		if (!RESET_N || !MEM_RD_REQ)
			lvl2_r <= 1'b0;
		else if (tk)
			lvl2_r <= !lvl2_r && MEM_RD_DATA[0];
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	l1_fault_end_a: assert property (tk && !lvl2_r && MEM_RD_DATA[1:0] == 2'b00
		|=> !MEM_RD_REQ && WALK_DONE) else $error("walk went on after invalid entry");
	sect_end_a: assert property (tk && !lvl2_r && MEM_RD_DATA[1:0] == 2'b10
		|=> !MEM_RD_REQ && WALK_DONE ##1 !WALK_DONE) else $error("section walk not ended");
	coarse_fetch_a: assert property (tk && !lvl2_r && MEM_RD_DATA[1:0] == 2'b01
		|=> MEM_RD_REQ && MEM_RD_ADDR[31:10] == d_last_r[31:10] && MEM_RD_ADDR[1:0] == 2'b00)
		else $error("coarse fetch address wrong");
	fine_fetch_a: assert property (tk && !lvl2_r && MEM_RD_DATA[1:0] == 2'b11
		|=> MEM_RD_REQ && MEM_RD_ADDR[31:12] == d_last_r[31:12] && MEM_RD_ADDR[1:0] == 2'b00)
		else $error("fine fetch address wrong");
	page_end_a: assert property (tk && lvl2_r |=> !MEM_RD_REQ && WALK_DONE)
		else $error("walk went on after second fetch");
	addr_hold_a: assert property (MEM_RD_REQ && !MEM_RD_ACK |=> MEM_RD_REQ && $stable(MEM_RD_ADDR))
		else $error("fetch address moved before answer");
	word_align_a: assert property ($rose(MEM_RD_REQ) |-> MEM_RD_ADDR[1:0] == 2'b00)
		else $error("first fetch not word aligned");
	done_cause_a: assert property (WALK_DONE |-> $past(tk))
		else $error("done pulse without final answer");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
endmodule : ptd_walker_checker
bind ptd_walker ptd_walker_checker i_ptd_walker_checker (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.MEM_RD_REQ(MEM_RD_REQ), .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_ACK(MEM_RD_ACK),
	.MEM_RD_DATA(MEM_RD_DATA), .WALK_DONE(WALK_DONE));
`default_nettype wire

/* File: bench/ptd_mem_model.sv */
// partner: table memory answering descriptor fetches after a set lag
`timescale 1ns/1ps
`default_nettype none
module ptd_mem_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req,
	input wire logic [31:0] addr,
	output logic ack,
	output logic [31:0] data,
	input wire logic [3:0] lag
);
	// ****************************************
	// storage and answer timing
	// ****************************************
	logic [31:0] mem [logic [31:0]];
	logic [31:0] seen_q [$];
	logic [3:0] wait_r;
	initial ack = 1'b0;
	initial data = 32'h5a5a_a5a5;
	always @(posedge sys_clk)
	begin
		ack <= 1'b0;
		data <= ~data;
		if (!reset_n)
			wait_r <= lag;
		else if (req && !ack)
		begin
			if (wait_r == 4'h0)
			begin
				ack <= 1'b1;
				data <= mem.exists(addr) ? mem[addr] : 32'h0;
				seen_q.push_back(addr);
				wait_r <= lag;
			end
			else
				wait_r <= wait_r - 4'h1;
		end
	end
endmodule : ptd_mem_model
`default_nettype wire

/* File: bench/tb_top.sv */
// testbench: register access and table walks against a table memory
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ptd_pkg::*;
	// ****************************************
	// stimulus, model and checks
	// ****************************************
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, e_phys = 32'h0, e_attr = 32'h0, r_val, e_val;
	logic [3:0] wstrb = 4'h0, lag = 4'h0, s_val;
	logic awready, wready, bvalid, arready, rvalid, mem_req, mem_ack, walk_done;
	logic [1:0] bresp, rresp, e_size = 2'b00;
	logic [31:0] rdata, mem_addr, mem_data;
	logic [3:0] cs [9] = '{4'h0, 4'h8, 4'h5, 4'h6, 4'h4, 4'hd, 4'he, 4'hf, 4'hc};
	int err_total = 0, n_checks = 0, cycles = 0, n_done = 0;
	int seed = 32'hb60dc736;
	always #25 sys_clk = ~sys_clk;
	ptd_walker i_ptd_walker (.SYS_CLK(sys_clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .MEM_RD_REQ(mem_req), .MEM_RD_ADDR(mem_addr),
		.MEM_RD_ACK(mem_ack), .MEM_RD_DATA(mem_data), .WALK_DONE(walk_done));
	ptd_mem_model i_ptd_mem_model (.sys_clk(sys_clk), .reset_n(reset_n), .req(mem_req),
		.addr(mem_addr), .ack(mem_ack), .data(mem_data), .lag(lag));
	task automatic summarize;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (walk_done)
			n_done <= n_done + 1;
		if (cycles == 8000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask : axw
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
	endtask : rc
	task automatic walk(input logic [1:0] t1, input logic [1:0] t2);
		logic [31:0] root, va, d1, d2, a1, a2, m;
		int n, n0;
		root = $random(seed);
		va = $random(seed);
		d1 = $random(seed);
		d2 = $random(seed);
		d1 = d1 & ~(t1 == 2'b10 ? 32'hff200 : t1 == 2'b01 ? 32'h20c : t1 == 2'b11 ? 32'he0c : 0);
		d1 = {d1[31:5], 1'b1, d1[3:2], t1};
		d2 = d2 & ~(t2 == 2'b01 ? 32'hf000 : t2 == 2'b11 ? 32'h3c0 : 32'h0);
		d2[1:0] = t2;
		a1 = {root[31:14], va[31:20], 2'b00};
		a2 = t1 == 2'b01 ? {d1[31:10], va[19:12], 2'b00} : {d1[31:12], va[19:10], 2'b00};
		n = t2 == 2'b01 ? (t1 == 2'b01 ? 16 : 64) : (t2 == 2'b10 && t1 == 2'b11) ? 4 : 1;
		i_ptd_mem_model.mem.delete();
		i_ptd_mem_model.seen_q.delete();
		i_ptd_mem_model.mem[a1] = d1;
		for (int i = 0; i < n && t1[0]; i++)
			i_ptd_mem_model.mem[(a2 & ~(32'(4 * n) - 32'h1)) + 32'(4 * i)] = d2;
		m = (32'h1 << (t2 == 2'b01 ? 16 : t2 == 2'b10 ? 12 : 10)) - 32'h1;
		if (t1 == 2'b10)
		begin
			e_phys = {d1[31:20], va[19:0]};
			e_attr = {15'h0, 1'b1, 6'h0, d1[11:10], 2'b00, d1[3:2], d1[8:5]};
			e_size = 2'b00;
		end
		else if (t1[0])
		begin
			e_attr[3:0] = d1[8:5];
			if (t2 != 2'b00)
			begin
				e_phys = (d2 & ~m) | (va & m);
				e_attr = {15'h0, t2 == 2'b11, t2 == 2'b11 ? {6'h0, d2[5:4]} : d2[11:4],
					2'b00, d2[3:2], d1[8:5]};
				e_size = t2;
			end
		end
		axw(OFS_ROOT, root, 4'hf, RESP_OKAY);
		axw(OFS_VADDR, va, 4'hf, RESP_OKAY);
		n0 = n_done;
		axw(OFS_CTRL, 32'h1, 4'h1, RESP_OKAY);
		if (lag != 4'h0)
			axw(OFS_VADDR, ~va, 4'hf, RESP_OKAY);
		while (n_done == n0)
			@(posedge sys_clk);
		chk(32'(i_ptd_mem_model.seen_q.size()), t1[0] ? 32'h2 : 32'h1);
		chk(i_ptd_mem_model.seen_q[0], a1);
		if (t1[0])
			chk(i_ptd_mem_model.seen_q[1], a2);
		rc(OFS_STATUS, {26'h0, e_size, t1[0] && t2 == 2'b00, t1 == 2'b00, 2'b10}, RESP_OKAY);
		rc(OFS_PHYS, e_phys, RESP_OKAY);
		rc(OFS_ATTR, e_attr, RESP_OKAY);
		rc(OFS_DESC1, d1, RESP_OKAY);
		rc(OFS_DESC2, t1[0] ? d2 : 32'h0, RESP_OKAY);
	endtask : walk
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int o = 0; o < 32; o += 4)
			rc(8'(o), RST_WORD, RESP_OKAY);
		rc(8'h20, 32'h0, RESP_SLVERR);
		rc(8'h06, 32'h0, RESP_SLVERR);
		axw(8'h24, 32'hffffffff, 4'hf, RESP_SLVERR);
		r_val = $random(seed);
		s_val = $random(seed);
		e_val = 32'hffffffff;
		for (int b = 0; b < 4; b++)
			if (s_val[b])
				e_val[8 * b +: 8] = r_val[8 * b +: 8];
		axw(OFS_ROOT, 32'hffffffff, 4'hf, RESP_OKAY);
		axw(OFS_ROOT, r_val, s_val, RESP_OKAY);
		rc(OFS_ROOT, e_val & 32'hffffc000, RESP_OKAY);
		for (int k = 0; k < 2; k++)
		begin
			lag <= k ? 4'h7 : 4'h0;
			for (int c = 0; c < 9; c++)
				walk(cs[c][3:2], cs[c][1:0]);
		end
		axw(OFS_STATUS, 32'h2, 4'hf, RESP_OKAY);
		rc(OFS_STATUS, {26'h0, e_size, 4'b1000}, RESP_OKAY);
		rc(OFS_CTRL, 32'h0, RESP_OKAY);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
